// *** mcs_defines.vh ***
// constants for the measurement cycle sequencer
`ifndef MCS_DEFINES_VH
`define MCS_DEFINES_VH

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define MCS_ADDR_CTRL      4'h0
`define MCS_ADDR_DELAY     4'h1
`define MCS_ADDR_FREQ      4'h2
`define MCS_ADDR_ITF       4'h3
`define MCS_ADDR_RANGE     4'h4
`define MCS_ADDR_STATUS    4'h5
`define MCS_ADDR_RESULT    4'h6
`define MCS_ADDR_CALC      4'h7

// --------------------------------------------------------------------
// control fields
// --------------------------------------------------------------------
`define MCS_CTRL_CONT      0
`define MCS_CTRL_HOLD      1
`define MCS_CTRL_MEDIAN    2
`define MCS_CTRL_DLY_EN    3
`define MCS_CTRL_RATE_LO   4
`define MCS_CTRL_RATE_HI   5
`define MCS_CTRL_RESET     32'h0000_0000

// --------------------------------------------------------------------
// rates, factor codes, ranges
// --------------------------------------------------------------------
`define MCS_RATE_FAST      2'h0
`define MCS_RATE_MEDIUM    2'h1
`define MCS_RATE_SLOW      2'h2
`define MCS_ITF_Q          2'h0
`define MCS_ITF_ONE        2'h1
`define MCS_ITF_SIX        2'h2
`define MCS_ITF_RESET      2'h1
`define MCS_RANGE_MIN      3'h1
`define MCS_RANGE_MAX      3'h4

// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define MCS_CLK_KHZ        50000
`define MCS_MS_CYC         (`MCS_CLK_KHZ)
`define MCS_SETTLE_FAST_MS 7
`define MCS_SETTLE_MED_MS  10
`define MCS_SETTLE_SLOW_MS 12
`define MCS_DELAY_MAX_MS   17'd99999
`define MCS_INT_SLOW_MS    100
`define MCS_CALC_DEF       32'h0000_0100

// --------------------------------------------------------------------
// value limits and range boundaries, with hysteresis
// --------------------------------------------------------------------
`define MCS_VAL_ZERO       32'h0000_0001
`define MCS_VAL_MAX        32'd99999
`define MCS_VAL_BLANK      32'hFFFF_FFFF
`define MCS_BOUND_LO       32'h0000_1000
`define MCS_BOUND_HI       32'h0001_0000
`define MCS_HYST           32'h0000_0080

`endif

// *** mcs_sequencer.v ***
// measurement cycle sequencer: settle, integrate, calculate, range decide
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "mcs_defines.vh"

module mcs_sequencer (
    // clock and reset
    input  wire        ref_clk,
    input  wire        srst,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // start source and converter
    input  wire        start,
    input  wire [31:0] conv_value,
    // cycle outputs
    output reg         integrating,
    output reg  [2:0]  range,
    output reg         result_valid,
    output reg  [31:0] result
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE   = 3'd0;
    localparam [2:0] ST_SETTLE = 3'd1;
    localparam [2:0] ST_INTEG  = 3'd2;
    localparam [2:0] ST_CALC   = 3'd3;
    localparam [2:0] ST_DECIDE = 3'd4;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [31:0] ctrl;
    reg  [16:0] delay_ms;
    reg  [15:0] freq_hz;
    reg  [1:0]  itf;
    reg  [31:0] calc_cyc;
    reg  [2:0]  state;
    reg  [31:0] cnt;
    reg  [1:0]  med_idx;
    reg  [31:0] samp0;
    reg  [31:0] samp1;
    reg  [31:0] samp2;
    reg  [7:0]  cycles;

    wire        cont    = ctrl[`MCS_CTRL_CONT];
    wire        hold    = ctrl[`MCS_CTRL_HOLD];
    wire        median  = ctrl[`MCS_CTRL_MEDIAN];
    wire        dly_en  = ctrl[`MCS_CTRL_DLY_EN];
    wire [1:0]  rate    = ctrl[`MCS_CTRL_RATE_HI:`MCS_CTRL_RATE_LO];
    wire [31:0] fz      = (freq_hz == 16'h0000) ? 32'h0000_0001 : {16'h0000, freq_hz};
    wire [31:0] period  = (`MCS_CLK_KHZ * 1000) / fz;

    // ----------------------------------------------------------------
    // interval lengths
    // ----------------------------------------------------------------
    reg  [31:0] settle_cyc;
    reg  [31:0] integ_cyc;
    reg  [31:0] next_range_val;

    always @* begin
        // settling scales with one period of the test signal, per ms/kHz
        case (rate)
            `MCS_RATE_FAST:   settle_cyc = period * `MCS_SETTLE_FAST_MS;
            `MCS_RATE_MEDIUM: settle_cyc = period * `MCS_SETTLE_MED_MS;
            default:          settle_cyc = period * `MCS_SETTLE_SLOW_MS;
        endcase
        if (dly_en) begin
            settle_cyc = {15'h0000, delay_ms} * `MCS_MS_CYC;
        end
        if (cont) begin
            settle_cyc = 32'h0000_0000;
        end
    end

    always @* begin
        // 1 kHz table scaled by period; slow rate fixed at 100 ms, fast quarter fixed at 1 ms above 1 kHz
        integ_cyc = `MCS_INT_SLOW_MS * `MCS_MS_CYC;
        if (rate == `MCS_RATE_FAST) begin
            case (itf)
                `MCS_ITF_Q: begin
                    if (freq_hz > 16'd1000) begin
                        integ_cyc = `MCS_MS_CYC;
                    end else begin
                        integ_cyc = period;
                    end
                end
                `MCS_ITF_SIX: integ_cyc = period * 24;
                default:      integ_cyc = period * 4;
            endcase
        end else if (rate == `MCS_RATE_MEDIUM) begin
            case (itf)
                `MCS_ITF_Q:   integ_cyc = period * 4;
                `MCS_ITF_SIX: integ_cyc = period * 100;
                default:      integ_cyc = period * 17;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // median of three, range decision with hysteresis
    // ----------------------------------------------------------------
    reg  [31:0] med_val;
    reg  [2:0]  next_range;

    always @* begin
        if ((samp0 >= samp1) == (samp0 <= samp2)) begin
            med_val = samp0;
        end else if ((samp1 >= samp0) == (samp1 <= samp2)) begin
            med_val = samp1;
        end else begin
            med_val = samp2;
        end
        next_range_val = median ? med_val : samp0;
        next_range = range;
        // value is impedance in-range; small means go up a range
        if (!hold) begin
            if (next_range_val < `MCS_BOUND_LO - `MCS_HYST
                && range != `MCS_RANGE_MAX) begin
                next_range = range + 3'h1;
            end else if (next_range_val > `MCS_BOUND_HI + `MCS_HYST
                && range != `MCS_RANGE_MIN) begin
                next_range = range - 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // register writes and sequencer
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            ctrl         <= `MCS_CTRL_RESET;
            delay_ms     <= 17'h0_0000;
            freq_hz      <= 16'd1000;
            itf          <= `MCS_ITF_RESET;
            calc_cyc     <= `MCS_CALC_DEF;
            state        <= ST_IDLE;
            cnt          <= 32'h0000_0000;
            med_idx      <= 2'h0;
            samp0        <= 32'h0000_0000;
            samp1        <= 32'h0000_0000;
            samp2        <= 32'h0000_0000;
            range        <= `MCS_RANGE_MIN;
            integrating  <= 1'b0;
            result_valid <= 1'b0;
            result       <= 32'h0000_0000;
            cycles       <= 8'h00;
        end else begin
            result_valid <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    `MCS_ADDR_CTRL:  ctrl <= reg_wdata;
                    `MCS_ADDR_DELAY: begin
                        if (reg_wdata[16:0] <= `MCS_DELAY_MAX_MS) begin
                            delay_ms <= reg_wdata[16:0];
                        end
                    end
                    `MCS_ADDR_FREQ:  freq_hz <= reg_wdata[15:0];
                    `MCS_ADDR_ITF: begin
                        if (reg_wdata[1:0] <= `MCS_ITF_SIX) begin
                            itf <= reg_wdata[1:0];
                        end
                    end
                    `MCS_ADDR_RANGE: begin
                        if (reg_wdata[2:0] >= `MCS_RANGE_MIN
                            && reg_wdata[2:0] <= `MCS_RANGE_MAX) begin
                            range <= reg_wdata[2:0];
                        end
                    end
                    `MCS_ADDR_CALC:  calc_cyc <= reg_wdata;
                    default: ;
                endcase
            end
            case (state)
                ST_IDLE: begin
                    if (cont || start) begin
                        state   <= ST_SETTLE;
                        cnt     <= 32'h0000_0000;
                        med_idx <= 2'h0;
                        cycles  <= 8'h00;
                    end
                end
                ST_SETTLE: begin
                    if (cnt + 32'h0000_0001 >= settle_cyc) begin
                        state       <= ST_INTEG;
                        cnt         <= 32'h0000_0000;
                        integrating <= 1'b1;
                    end else begin
                        cnt <= cnt + 32'h0000_0001;
                    end
                end
                ST_INTEG: begin
                    if (cnt + 32'h0000_0001 >= integ_cyc) begin
                        state       <= ST_CALC;
                        cnt         <= 32'h0000_0000;
                        integrating <= 1'b0;
                        case (med_idx)
                            2'h0:    samp0 <= conv_value;
                            2'h1:    samp1 <= conv_value;
                            default: samp2 <= conv_value;
                        endcase
                    end else begin
                        cnt <= cnt + 32'h0000_0001;
                    end
                end
                ST_CALC: begin
                    if (cnt + 32'h0000_0001 >= calc_cyc) begin
                        cnt <= 32'h0000_0000;
                        if (median && med_idx != 2'h2) begin
                            med_idx     <= med_idx + 2'h1;
                            state       <= ST_INTEG;
                            integrating <= 1'b1;
                        end else begin
                            state <= ST_DECIDE;
                        end
                    end else begin
                        cnt <= cnt + 32'h0000_0001;
                    end
                end
                ST_DECIDE: begin
                    cycles  <= cycles + 8'h01;
                    med_idx <= 2'h0;
                    if (next_range != range) begin
                        range       <= next_range;
                        state       <= ST_INTEG;
                        integrating <= 1'b1;
                    end else begin
                        result_valid <= 1'b1;
                        if (next_range_val < `MCS_VAL_ZERO) begin
                            result <= 32'h0000_0000;
                        end else if (next_range_val > `MCS_VAL_MAX) begin
                            result <= `MCS_VAL_BLANK;
                        end else begin
                            result <= next_range_val;
                        end
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `MCS_ADDR_CTRL:   reg_rdata <= ctrl;
                `MCS_ADDR_DELAY:  reg_rdata <= {15'h0000, delay_ms};
                `MCS_ADDR_FREQ:   reg_rdata <= {16'h0000, freq_hz};
                `MCS_ADDR_ITF:    reg_rdata <= {30'h0000_0000, itf};
                `MCS_ADDR_RANGE:  reg_rdata <= {29'h0000_0000, range};
                `MCS_ADDR_STATUS: reg_rdata <= {21'h00_0000, cycles, state};
                `MCS_ADDR_RESULT: reg_rdata <= result;
                `MCS_ADDR_CALC:   reg_rdata <= calc_cyc;
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // mcs_sequencer

// *** mcs_start_src.sv ***
// start source model: a handler issuing one start pulse per wanted measurement
`timescale 1ns/100ps

module mcs_start_src (
    // clock
    input  wire  ref_clk,
    // start line to the sequencer
    output logic start
);
    initial start = 1'b0;

    // one pulse per measurement, changed just after an edge
    task automatic fire();
        @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
    endtask
endmodule // mcs_start_src

// *** mcs_sequencer_chk.sv ***
// checker for the measurement cycle sequencer ports
`timescale 1ns/100ps
`include "mcs_defines.vh"

module mcs_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // start and converter
    input wire logic        start,
    input wire logic [31:0] conv_value,
    // cycle outputs
    input wire logic        integrating,
    input wire logic [2:0]  range,
    input wire logic        result_valid,
    input wire logic [31:0] result
);
    localparam int IQ_LO = 49998;
    localparam int IQ_HI = 50002;
    logic [5:0]  ctrl_q;
    logic [1:0]  itf_q;
    logic [31:0] freq_q;
    logic        pend;
    int          run;

    // --------------------------------------------------------------
    // shadow of settings and a start seen since the last result
    // --------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q <= 6'h0;
            itf_q  <= `MCS_ITF_RESET;
            freq_q <= 32'h0000_03E8;
            pend   <= 1'b0;
            run    <= 0;
        end else begin
            if (reg_wr && reg_addr == `MCS_ADDR_CTRL) ctrl_q <= reg_wdata[5:0];
            if (reg_wr && reg_addr == `MCS_ADDR_ITF && reg_wdata <= 32'h0000_0002)
                itf_q <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `MCS_ADDR_FREQ) freq_q <= reg_wdata;
            pend <= start ? 1'b1 : (result_valid ? 1'b0 : pend);
            run  <= integrating ? run + 1 : 0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    a_range_legal: assert property (range >= `MCS_RANGE_MIN && range <= `MCS_RANGE_MAX)
        else $error("range outside 1..4");
    a_range_write: assert property (reg_wr && reg_addr == `MCS_ADDR_RANGE &&
        reg_wdata >= 32'h0000_0001 && reg_wdata <= 32'h0000_0004 |=> range == $past(reg_wdata[2:0]))
        else $error("range write not applied");
    a_hold_keeps_range: assert property (ctrl_q[`MCS_CTRL_HOLD] &&
        !(reg_wr && reg_addr == `MCS_ADDR_RANGE) |=> $stable(range))
        else $error("range moved while held");
    a_start_begins: assert property ($rose(integrating) && !ctrl_q[`MCS_CTRL_CONT] |-> pend)
        else $error("triggered cycle began without start");
    a_span_limits: assert property (result_valid |->
        (result <= `MCS_VAL_MAX || result == `MCS_VAL_BLANK))
        else $error("result beyond display span");
    a_valid_one_cycle: assert property (result_valid |=> !result_valid)
        else $error("result valid longer than one cycle");
    a_decide_after_integ: assert property (result_valid |-> !integrating)
        else $error("result while integrating");
    a_quarter_one_ms: assert property ($fell(integrating) && ctrl_q[5:4] == `MCS_RATE_FAST &&
        itf_q == `MCS_ITF_Q && freq_q > 32'h0000_03E8 |-> run >= IQ_LO && run <= IQ_HI)
        else $error("quarter factor integration not one ms");

    c_result: cover property (result_valid);
    c_integ_done: cover property ($fell(integrating));
    c_trig_start: cover property ($rose(integrating) && pend);
endmodule // mcs_chk

bind mcs_sequencer mcs_chk u_mcs_chk (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start(start),
    .conv_value(conv_value), .integrating(integrating), .range(range),
    .result_valid(result_valid), .result(result));

// *** testbench.sv ***
// self-checking testbench for the measurement cycle sequencer
`timescale 1ns/100ps
`include "mcs_defines.vh"

module testbench;
    logic        ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, conv_value = 32'h0000_0000, d;
    wire         start, integrating, result_valid;
    wire  [2:0]  range;
    wire  [31:0] reg_rdata, result;
    int          mismatches = 0;
    int          n_checks = 0;
    int          n;

    always #10 ref_clk = ~ref_clk;

    mcs_sequencer u_mcs_sequencer (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .start(start), .conv_value(conv_value), .integrating(integrating), .range(range),
        .result_valid(result_valid), .result(result));
    mcs_start_src u_mcs_start_src (.ref_clk(ref_clk), .start(start));

    // --------------------------------------------------------------
    // common tasks
    // --------------------------------------------------------------
    task automatic report_and_stop();
        if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_in(input string what, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    // bounded wait for integrating to reach a level
    task automatic wait_integ(input logic lvl, input int bound, output int cnt);
        cnt = 0;
        #1;
        while (integrating !== lvl) begin
            @(posedge ref_clk);
            #1;
            cnt++;
            if (cnt > bound) begin
                chk("integrating wait", {31'h0, lvl}, {31'h0, integrating});
                report_and_stop();
            end
        end
    endtask
    // one triggered cycle: settle, integration within the given bounds, result
    task automatic run_cycle(input int s_lo, input int s_hi, input int i_lo, input int i_hi,
                             input logic [31:0] exp);
        u_mcs_start_src.fire();
        wait_integ(1'b1, 20000, n);
        chk_in("settle cycles", s_lo, s_hi, n);
        wait_integ(1'b0, 60000, n);
        chk_in("integrate cycles", i_lo, i_hi, n);
        n = 0;
        while (result_valid !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("result valid", 32'h0000_0001, {31'h0, result_valid});
        if (n >= 200) begin
            report_and_stop();
        end
        chk("result", exp, result);
        chk("range held", 32'h0000_0003, {29'h0, range});
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset_vals();
        rd(`MCS_ADDR_CTRL, d); chk("ctrl reset", 32'h0000_0000, d);
        rd(`MCS_ADDR_ITF, d); chk("factor reset", 32'h0000_0001, d);
        rd(`MCS_ADDR_FREQ, d); chk("freq reset", 32'h0000_03E8, d);
        rd(`MCS_ADDR_CALC, d); chk("calc reset", `MCS_CALC_DEF, d);
        rd(4'hF, d); chk("unmapped", 32'h0000_0000, d);
        chk("range reset", 32'h0000_0001, {29'h0, range});
    endtask
    task automatic t_refusals();
        wr(`MCS_ADDR_ITF, 32'h0000_0003);
        rd(`MCS_ADDR_ITF, d); chk("factor over max", 32'h0000_0001, d);
        wr(`MCS_ADDR_ITF, 32'h0000_0000);
        rd(`MCS_ADDR_ITF, d); chk("factor quarter", 32'h0000_0000, d);
        wr(`MCS_ADDR_DELAY, 32'h0001_869F);
        wr(`MCS_ADDR_DELAY, 32'h0001_86A0);
        rd(`MCS_ADDR_DELAY, d); chk("delay max", 32'h0001_869F, d);
        wr(`MCS_ADDR_RANGE, 32'h0000_0005);
        wr(`MCS_ADDR_RANGE, 32'h0000_0000);
        chk("range refused", 32'h0000_0001, {29'h0, range});
        wr(`MCS_ADDR_RANGE, 32'h0000_0003);
        chk("range set", 32'h0000_0003, {29'h0, range});
    endtask
    task automatic t_no_start();
        wr(`MCS_ADDR_CTRL, 32'h0000_0002);
        wr(`MCS_ADDR_FREQ, 32'h0000_C350);
        wr(`MCS_ADDR_CALC, 32'h0000_0004);
        repeat (300) @(posedge ref_clk);
        #1;
        chk("idle without start", 32'h0000_0000, {31'h0, integrating});
    endtask
    task automatic t_trig_settle();
        conv_value <= 32'h0000_2000;
        run_cycle(6990, 7010, 49998, 50002, 32'h0000_2000);
    endtask
    task automatic t_delay_blank();
        wr(`MCS_ADDR_DELAY, 32'h0000_0000);
        wr(`MCS_ADDR_CTRL, 32'h0000_001A);
        conv_value <= 32'h0001_86A0;
        run_cycle(1, 4, 3998, 4002, `MCS_VAL_BLANK);
    endtask
    // continuous, medium rate: discard the first result, keep the second
    task automatic t_continuous();
        conv_value <= 32'h0000_0300;
        wr(`MCS_ADDR_CTRL, 32'h0000_0013);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (result_valid !== 1'b1 && n < 6000) begin
                @(posedge ref_clk);
                #1;
                n++;
            end
            chk_in("continuous re-arm cycles", 0, 5999, n);
            if (n >= 6000) begin
                report_and_stop();
            end
            @(posedge ref_clk);
            #1;
        end
        chk("second continuous result", 32'h0000_0300, result);
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset_vals();
        t_refusals();
        t_no_start();
        t_trig_settle();
        t_delay_blank();
        t_continuous();
        report_and_stop();
    end
endmodule // testbench
